/* File: hw/flash_seq_regs.svh */
// constants for the flash row write latch sequencer
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

`define UNLOCK_KEY_FIRST   8'h55
`define UNLOCK_KEY_SECOND  8'hAA
`define LATCH_ERASED_VALUE 16'h7FFF
`define NUM_WRITE_LATCHES  32
`define ADDR_HIGH_W        7
`define BYTE_W             8
`define ADDR_W             15
`define ROW_W              10
`define LATCH_IDX_W        5
`define WORD_W             16
`define ADDR_RESET         15'h0000
`define BYTE_RESET         8'h00

`endif

/* File: hw/flash_seq_pkg.sv */
// types for the flash row write latch sequencer
package flash_seq_pkg;

    typedef enum logic [2:0] {
        U_NONE = 3'b001,
        U_KEY1 = 3'b010,
        U_KEY2 = 3'b100
    } unlock_state_t;

    typedef enum logic [4:0] {
        M_IDLE  = 5'b00001,
        M_PROG  = 5'b00010,
        M_PWAIT = 5'b00100,
        M_ERASE = 5'b01000,
        M_EWAIT = 5'b10000
    } main_state_t;

endpackage

/* File: hw/latch_bus_if.sv */
// write latch bank access between sequencer and bank
`timescale 1ns/1ps
interface latch_bus_if #(
    parameter int IDX_W  = 5,
    parameter int WORD_W = 16
);
    logic              wr_en;
    logic [IDX_W-1:0]  wr_idx;
    logic [WORD_W-1:0] wr_data;
    logic              clr;
    logic [IDX_W-1:0]  rd_idx;
    logic [WORD_W-1:0] rd_data;

    modport seq  (output wr_en, wr_idx, wr_data, clr, rd_idx, input rd_data);
    modport bank (input wr_en, wr_idx, wr_data, clr, rd_idx, output rd_data);
endinterface

/* File: hw/write_latch_bank.sv */
// bank of program flash write latches
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module write_latch_bank
    import flash_seq_pkg::*;
#(
    parameter int NUM_LATCH = `NUM_WRITE_LATCHES,
    parameter int IDX_W     = `LATCH_IDX_W
) (
    input wire logic   mclk_in,
    input wire logic   rst_n_in,
    latch_bus_if.bank  bus
);
    logic [`WORD_W-1:0] mem_q [NUM_LATCH];

    initial begin
        if (NUM_LATCH != (1 << IDX_W)) begin
            $error("latch count must equal two to the index width");
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < NUM_LATCH; i++) begin
                mem_q[i] <= `LATCH_ERASED_VALUE;
            end
        end else if (bus.clr) begin
            for (int i = 0; i < NUM_LATCH; i++) begin
                mem_q[i] <= `LATCH_ERASED_VALUE;
            end
        end else if (bus.wr_en) begin
            mem_q[bus.wr_idx] <= bus.wr_data;
        end
    end

    assign bus.rd_data = mem_q[bus.rd_idx];
endmodule

/* File: hw/flash_row_write_latch_sequencer.sv */
// flash row write latch sequencer: unlock, latch load, row program and erase
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_row_write_latch_sequencer
    import flash_seq_pkg::*;
#(
    parameter int NUM_LATCH = `NUM_WRITE_LATCHES
) (
    input  wire logic                     mclk_in,
    input  wire logic                     rst_n_in,
    // software side
    input  wire logic [`BYTE_W-1:0]       wdata_in,
    input  wire logic                     addr_high_wr_in,
    input  wire logic                     addr_low_wr_in,
    input  wire logic                     data_high_wr_in,
    input  wire logic                     data_low_wr_in,
    input  wire logic                     key_wr_in,
    input  wire logic                     start_wr_in,
    input  wire logic                     other_access_in,
    input  wire logic                     write_permit_in,
    input  wire logic                     config_space_select_in,
    input  wire logic                     latch_only_in,
    input  wire logic                     row_erase_in,
    output logic [`ADDR_W-1:0]            flash_addr_out,
    output logic [`WORD_W-1:0]            flash_data_out,
    output logic                          busy_out,
    output logic                          unlock_armed_out,
    output logic                          latch_loaded_out,
    output logic                          op_done_out,
    // flash array side
    output logic                          prog_valid_out,
    output logic                          erase_req_out,
    output logic [`ADDR_W-1:0]            prog_addr_out,
    output logic [`WORD_W-1:0]            prog_data_out,
    input  wire logic                     prog_ready_in,
    input  wire logic                     flash_done_in
);
    localparam int IDX_W = `LATCH_IDX_W;

    initial begin
        if (NUM_LATCH != (1 << IDX_W)) begin
            $error("latch count must equal two to the index width");
        end
    end

    unlock_state_t unlock_q, unlock_d;
    main_state_t   main_q, main_d;

    logic [`ADDR_HIGH_W-1:0] addr_high_q;
    logic [`BYTE_W-1:0]      addr_low_q;
    logic [`BYTE_W-1:0]      data_high_q;
    logic [`BYTE_W-1:0]      data_low_q;
    logic [`ROW_W-1:0]       row_q;
    logic [IDX_W-1:0]        cnt_q, cnt_d;
    logic                    loaded_q;
    logic                    done_q;

    latch_bus_if #(.IDX_W(IDX_W), .WORD_W(`WORD_W)) lat ();

    write_latch_bank #(
        .NUM_LATCH (NUM_LATCH),
        .IDX_W     (IDX_W)
    ) u_bank (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .bus      (lat.bank)
    );

    // decoding
    wire logic [`ADDR_W-1:0] cur_addr   = {addr_high_q, addr_low_q};
    wire logic [`ROW_W-1:0]  cur_row    = cur_addr[`ADDR_W-1:IDX_W];
    wire logic [IDX_W-1:0]   cur_idx    = cur_addr[IDX_W-1:0];
    wire logic               idle       = (main_q == M_IDLE);
    wire logic               reg_write  = addr_high_wr_in | addr_low_wr_in
                                        | data_high_wr_in | data_low_wr_in;
    wire logic               key1_ok    = key_wr_in && (wdata_in == `UNLOCK_KEY_FIRST);
    wire logic               key2_ok    = key_wr_in && (wdata_in == `UNLOCK_KEY_SECOND);
    wire logic               abort_acc  = reg_write | other_access_in;
    wire logic               permitted  = write_permit_in && !config_space_select_in;
    // start counts only right after both keys
    wire logic               start_ok   = start_wr_in && (unlock_q == U_KEY2)
                                        && permitted && idle;
    // latch only mode loads one latch
    wire logic               do_load    = start_ok && latch_only_in;
    // program all latches into the row
    wire logic               do_prog    = start_ok && !latch_only_in && !row_erase_in;
    // erase request is whole row only
    wire logic               do_erase   = start_ok && !latch_only_in && row_erase_in;
    wire logic               last_word  = (cnt_q == IDX_W'(NUM_LATCH - 1));
    wire logic               prog_fire  = (main_q == M_PROG) && prog_ready_in;

    always_comb begin
        unlock_d = unlock_q;
        unique case (unlock_q)
            U_NONE: begin
                if (key1_ok && !abort_acc && !start_wr_in) begin
                    unlock_d = U_KEY1;
                end
            end
            U_KEY1: begin
                if (key2_ok && !abort_acc && !start_wr_in) begin
                    unlock_d = U_KEY2;
                end else if (key_wr_in || abort_acc || start_wr_in) begin
                    unlock_d = U_NONE;
                end
            end
            U_KEY2: begin
                if (key_wr_in || abort_acc || start_wr_in) begin
                    unlock_d = U_NONE;
                end
            end
        endcase
    end

    // main operation state machine
    always_comb begin
        main_d = main_q;
        cnt_d  = cnt_q;
        unique case (main_q)
            M_IDLE: begin
                cnt_d = '0;
                if (do_prog) begin
                    main_d = M_PROG;
                end else if (do_erase) begin
                    main_d = M_ERASE;
                end
            end
            M_PROG: begin
                // walk exactly the latches of one row
                if (prog_fire) begin
                    cnt_d = cnt_q + IDX_W'(1);
                    if (last_word) begin
                        main_d = M_PWAIT;
                    end
                end
            end
            M_PWAIT: begin
                if (flash_done_in) begin
                    main_d = M_IDLE;
                end
            end
            M_ERASE: begin
                if (prog_ready_in) begin
                    main_d = M_EWAIT;
                end
            end
            M_EWAIT: begin
                if (flash_done_in) begin
                    main_d = M_IDLE;
                end
            end
        endcase
    end

    // full fifteen bit word address held
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_high_q <= `ADDR_HIGH_W'(`ADDR_RESET >> `BYTE_W);
            addr_low_q  <= `BYTE_RESET;
            data_high_q <= `BYTE_RESET;
            data_low_q  <= `BYTE_RESET;
        end else begin
            if (addr_high_wr_in) addr_high_q <= wdata_in[`ADDR_HIGH_W-1:0];
            if (addr_low_wr_in)  addr_low_q  <= wdata_in;
            if (data_high_wr_in) data_high_q <= wdata_in;
            if (data_low_wr_in)  data_low_q  <= wdata_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            unlock_q <= U_NONE;
            main_q   <= M_IDLE;
            cnt_q    <= '0;
            row_q    <= '0;
            loaded_q <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            unlock_q <= unlock_d;
            main_q   <= main_d;
            cnt_q    <= cnt_d;
            loaded_q <= do_load;
            done_q   <= flash_done_in && (main_q == M_PWAIT || main_q == M_EWAIT);
            if (start_ok) row_q <= cur_row;
        end
    end

    // latch load from data pair at index
    assign lat.wr_en   = do_load;
    assign lat.wr_idx  = cur_idx;
    assign lat.wr_data = {data_high_q, data_low_q};
    // reset latches when a program completes
    assign lat.clr     = (main_q == M_PWAIT) && flash_done_in;
    assign lat.rd_idx  = cnt_q;

    assign erase_req_out    = (main_q == M_ERASE);
    assign prog_valid_out   = (main_q == M_PROG);
    assign prog_addr_out    = {row_q, (main_q == M_PROG) ? cnt_q : IDX_W'(0)};
    assign prog_data_out    = lat.rd_data;
    assign flash_addr_out   = cur_addr;
    assign flash_data_out   = {data_high_q, data_low_q};
    assign busy_out         = !idle;
    assign unlock_armed_out = (unlock_q == U_KEY2);
    assign latch_loaded_out = loaded_q;
    assign op_done_out      = done_q;

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);

    property p_unlock_before_load;
        lat.wr_en |-> unlock_q == U_KEY2 && start_wr_in && latch_only_in ##1 unlock_q == U_NONE;
    endproperty
    a_unlock_before_load: assert property (p_unlock_before_load)
        else $error("latch loaded without full unlock");

    property p_abort_unlock;
        (unlock_q != U_NONE) && (other_access_in || reg_write) |=> unlock_q == U_NONE;
    endproperty
    a_abort_unlock: assert property (p_abort_unlock)
        else $error("interrupted unlock not aborted");

    property p_latch_only_no_prog;
        do_load |=> main_q == M_IDLE && latch_loaded_out && !prog_valid_out;
    endproperty
    a_latch_only_no_prog: assert property (p_latch_only_no_prog)
        else $error("latch only start began a program");

    property p_prog_start;
        start_ok && !latch_only_in && !row_erase_in |=> prog_valid_out && cnt_q == '0;
    endproperty
    a_prog_start: assert property (p_prog_start)
        else $error("program did not start");

    property p_permit;
        !write_permit_in && idle |-> !lat.wr_en ##1 idle;
    endproperty
    a_permit: assert property (p_permit)
        else $error("action taken without write permit");

    property p_row_confined;
        prog_valid_out |-> prog_addr_out[`ADDR_W-1:IDX_W] == row_q
            ##1 (!prog_valid_out || $stable(row_q));
    endproperty
    a_row_confined: assert property (p_row_confined)
        else $error("program left its row");

    property p_word_count;
        prog_fire && last_word |=> main_q == M_PWAIT && !prog_valid_out;
    endproperty
    a_word_count: assert property (p_word_count)
        else $error("program word count wrong");

    property p_latch_reset;
        (main_q == M_PWAIT) && flash_done_in |=> lat.rd_data == `LATCH_ERASED_VALUE
            && main_q == M_IDLE;
    endproperty
    a_latch_reset: assert property (p_latch_reset)
        else $error("latches not reset after program");

    property p_no_auto_erase;
        $rose(erase_req_out) |-> $past(row_erase_in) && $past(!latch_only_in);
    endproperty
    a_no_auto_erase: assert property (p_no_auto_erase)
        else $error("erase without explicit row erase");

    property p_erase_whole_row;
        erase_req_out |-> prog_addr_out[IDX_W-1:0] == '0 && !prog_valid_out;
    endproperty
    a_erase_whole_row: assert property (p_erase_whole_row)
        else $error("erase not row aligned");

    property p_load_index;
        lat.wr_en |-> lat.wr_idx == addr_low_q[IDX_W-1:0]
            && lat.wr_data == {data_high_q, data_low_q};
    endproperty
    a_load_index: assert property (p_load_index)
        else $error("latch index or data wrong");

    property p_address_range;
        $past(addr_high_wr_in) |-> flash_addr_out[`ADDR_W-1:`BYTE_W]
            == $past(wdata_in[`ADDR_HIGH_W-1:0]);
    endproperty
    a_address_range: assert property (p_address_range)
        else $error("high address bits lost");

    property p_space_blocks;
        config_space_select_in && idle |-> !lat.wr_en ##1 idle;
    endproperty
    a_space_blocks: assert property (p_space_blocks)
        else $error("action taken with config space selected");

    property p_done_pulse;
        flash_done_in && (main_q == M_PWAIT || main_q == M_EWAIT) |=> op_done_out && idle
            ##1 !op_done_out;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("completion pulse wrong");

    property p_busy_refuses;
        start_wr_in && (unlock_q == U_KEY2) && !idle |-> !lat.wr_en ##1 unlock_q == U_NONE;
    endproperty
    a_busy_refuses: assert property (p_busy_refuses)
        else $error("start taken while busy");
endmodule

/* File: bench/flash_array_model.sv */
// behavioural model of the program flash row array
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module flash_array_model (
    input  wire logic                mclk_in,
    input  wire logic                rst_n_in,
    input  wire logic                slow_in,
    input  wire logic                prog_valid_in,
    input  wire logic                erase_req_in,
    input  wire logic [`ADDR_W-1:0]  prog_addr_in,
    input  wire logic [`WORD_W-1:0]  prog_data_in,
    output logic                     prog_ready_out,
    output logic                     flash_done_out
);
    logic [`WORD_W-1:0]      words_q [`NUM_WRITE_LATCHES];
    logic [`ROW_W-1:0]       row_q;
    logic                    row_bad_q;
    logic                    tog_q;
    int                      taken_q;
    int                      erases_q;
    int                      wait_q;
    wire logic [4:0]         idx = prog_addr_in[`LATCH_IDX_W-1:0];
    wire logic [`ROW_W-1:0]  row = prog_addr_in[`ADDR_W-1:`LATCH_IDX_W];
    // slow mode accepts every other cycle
    assign prog_ready_out = (prog_valid_in | erase_req_in) & (~slow_in | tog_q);
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < `NUM_WRITE_LATCHES; i++) words_q[i] <= '0;
            {row_q, row_bad_q, tog_q, flash_done_out} <= '0;
            {taken_q, erases_q, wait_q} <= '0;
        end else begin
            tog_q <= ~tog_q;
            flash_done_out <= (wait_q == 1);
            if (wait_q != 0) wait_q <= wait_q - 1;
            // one word per handshake, stored as given
            if (prog_valid_in & prog_ready_out) begin
                words_q[idx] <= prog_data_in;
                taken_q <= taken_q + 1;
                row_q <= row;
                // row must stay fixed within one program
                if (idx != 5'h0 && row != row_q) row_bad_q <= 1'b1;
                if (idx == 5'h1f) wait_q <= 3;
            end
            // erase covers the addressed row only
            if (erase_req_in & prog_ready_out) begin
                erases_q <= erases_q + 1;
                row_q <= row;
                wait_q <= 3;
            end
        end
    end
endmodule

/* File: bench/test_flash_row_write_latch_sequencer.sv */
// self-checking bench for the flash row write latch sequencer
`timescale 1ns/1ps
`include "flash_seq_regs.svh"
module test_flash_row_write_latch_sequencer;
    typedef struct packed {
        logic [14:0] a;
        logic [15:0] d;
        logic        lo, pm, sp, ld;
    } row_t;
    logic        mclk, rst_n, permit, space, lonly, erase, slow, seen;
    logic [7:0]  wdata;
    logic [6:0]  stb;
    logic [14:0] faddr, paddr;
    logic [15:0] fdata, pdata;
    logic [15:0] exp_w [32];
    logic        busy, armed, loaded, done, pvalid, ereq, pready, fdone;
    int          failures, samples_checked;
    row_t        r;
    row_t        rows [5] = '{{15'h7fe0, 16'h1234, 4'b1101}, {15'h7fe1, 16'habcd, 4'b1101},
                              {15'h7fe2, 16'h5555, 4'b1000}, {15'h7fe3, 16'h6666, 4'b1110},
                              {15'h7fff, 16'h0f0f, 4'b1101}};

    flash_row_write_latch_sequencer u_dut (
        .mclk_in(mclk), .rst_n_in(rst_n), .wdata_in(wdata),
        .addr_high_wr_in(stb[0]), .addr_low_wr_in(stb[1]), .data_high_wr_in(stb[2]),
        .data_low_wr_in(stb[3]), .key_wr_in(stb[4]), .start_wr_in(stb[5]),
        .other_access_in(stb[6]), .write_permit_in(permit), .config_space_select_in(space),
        .latch_only_in(lonly), .row_erase_in(erase), .flash_addr_out(faddr),
        .flash_data_out(fdata), .busy_out(busy), .unlock_armed_out(armed),
        .latch_loaded_out(loaded), .op_done_out(done), .prog_valid_out(pvalid),
        .erase_req_out(ereq), .prog_addr_out(paddr), .prog_data_out(pdata),
        .prog_ready_in(pready), .flash_done_in(fdone));

    flash_array_model u_model (
        .mclk_in(mclk), .rst_n_in(rst_n), .slow_in(slow), .prog_valid_in(pvalid),
        .erase_req_in(ereq), .prog_addr_in(paddr), .prog_data_in(pdata),
        .prog_ready_out(pready), .flash_done_out(fdone));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0, got}, {15'h0, exp});
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic pulse(input int k, input logic [7:0] d);
        @(posedge mclk);
        stb <= 7'(1 << k);
        wdata <= d;
        @(posedge mclk);
        stb <= '0;
    endtask

    task automatic unlock();
        pulse(4, 8'h55);
        pulse(4, 8'haa);
        pulse(5, 8'h00);
    endtask

    // pulse flags may show just after the start edge or one cycle later
    task automatic catch(output logic s, input logic which);
        #1 s = which ? loaded : ereq;
        @(posedge mclk);
        #1 s = s | (which ? loaded : ereq);
    endtask

    task automatic wait_done();
        int n;
        for (n = 0; n < 2000; n++) begin
            @(posedge mclk);
            #1;
            if (done === 1'b1) break;
        end
        if (n == 2000) begin
            failures++;
            test_done();
        end
    endtask

    initial begin
        {rst_n, permit, space, lonly, erase, slow, wdata, stb} <= '0;
        {failures, samples_checked} = '0;
        for (int i = 0; i < 32; i++) exp_w[i] = 16'h7fff;
        repeat (5) @(posedge mclk);
        #1 chk_word(pdata, 16'h7fff);
        chk_bit(busy | pvalid | ereq, 1'b0);
        @(posedge mclk);
        rst_n <= 1'b1;
        $display("done: reset");
        // rows step the address by one per row, the last jumps to 7fff
        for (int i = 0; i < 5; i++) begin
            r = rows[i];
            @(posedge mclk);
            // permit, space select and latch only per row
            {lonly, permit, space} <= {r.lo, r.pm, r.sp};
            pulse(0, {1'b0, r.a[14:8]});
            pulse(1, r.a[7:0]);
            pulse(2, r.d[15:8]);
            pulse(3, r.d[7:0]);
            pulse(4, 8'h55);
            pulse(4, 8'haa);
            #1 chk_bit(armed, 1'b1);
            pulse(5, 8'h00);
            catch(seen, 1'b1);
            chk_bit(seen, r.ld);
            chk_word({1'b0, faddr}, {1'b0, r.a});
            chk_word(fdata, r.d);
            if (r.ld) exp_w[r.a[4:0]] = r.d;
        end
        $display("done: latch loads");
        @(posedge mclk);
        {lonly, permit, space} <= 3'b110;
        pulse(4, 8'h55);
        pulse(6, 8'h00);
        pulse(4, 8'haa);
        pulse(5, 8'h00);
        catch(seen, 1'b1);
        chk_bit(seen, 1'b0);
        pulse(4, 8'h55);
        pulse(4, 8'haa);
        pulse(3, 8'h22);
        pulse(5, 8'h00);
        catch(seen, 1'b1);
        chk_bit(seen, 1'b0);
        chk_word(16'(u_model.taken_q), 16'h0);
        $display("done: broken unlock");
        @(posedge mclk);
        lonly <= 1'b0;
        unlock();
        #1 chk_bit(busy, 1'b1);
        wait_done();
        chk_word(16'(u_model.taken_q), 16'h0020);
        chk_word({6'h0, u_model.row_q}, 16'h03ff);
        chk_bit(u_model.row_bad_q, 1'b0);
        for (int i = 0; i < 32; i++) chk_word(u_model.words_q[i], exp_w[i]);
        @(posedge mclk);
        #1 chk_word(pdata, 16'h7fff);
        $display("done: row program");
        @(posedge mclk);
        slow <= 1'b1;
        unlock();
        unlock();
        wait_done();
        repeat (8) @(posedge mclk);
        chk_word(16'(u_model.taken_q), 16'h0040);
        for (int i = 0; i < 32; i++) chk_word(u_model.words_q[i], 16'h7fff);
        $display("done: slow program");
        pulse(0, 8'h00);
        pulse(1, 8'h40);
        @(posedge mclk);
        erase <= 1'b1;
        unlock();
        catch(seen, 1'b0);
        chk_bit(seen, 1'b1);
        wait_done();
        chk_word(16'(u_model.erases_q), 16'h0001);
        chk_word({6'h0, u_model.row_q}, 16'h0002);
        chk_word(16'(u_model.taken_q), 16'h0040);
        $display("done: row erase");
        test_done();
    end
endmodule
